// ### verilog/wwdt_core.sv
// Windowed watchdog top: Avalon-MM registers, tick-domain counter, early warning and system reset.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module wwdt_core (
  input  wire logic        I_CLK,
  input  wire logic        I_SRST,
  input  wire logic        I_WDT_TICK_CLK,
  input  wire logic        I_DBG_HALT,
  input  wire logic        I_BACKUP_MODE,
  input  wire logic        I_NVM_ENABLE,
  input  wire logic        I_NVM_LOCK,
  input  wire logic        I_NVM_WEN,
  input  wire logic [3:0]  I_NVM_WINDOW,
  input  wire logic [3:0]  I_NVM_PER,
  input  wire logic [3:0]  I_NVM_EWOFF,
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  output logic             O_IRQ,
  output logic             O_WAKE,
  output logic             O_SYS_RESET
);
  function automatic logic [16:0] period_cycles(input logic [3:0] code);
    if (code > wwdt_pkg::CODE_MAX) begin
      return wwdt_pkg::PERIOD_TOP;
    end
    return wwdt_pkg::PERIOD_BASE << code;
  endfunction

  logic        por_load;
  logic        ctrl_enable;
  logic        ctrl_wen;
  logic        lock;
  logic        en_eff;
  logic        wen_eff;
  logic        lock_eff;
  logic [3:1]  sync_busy;
  logic [3:0]  win_code;
  logic [3:0]  per_code;
  logic [3:0]  ew_code;
  logic        irq_en;
  logic        irq_flag;
  logic [7:0]  clear_val;
  logic [16:0] cnt;
  logic [1:0]  bus_cnt;
  logic        tick;

  wwdt_tick_sync u_tick (
    .i_clk      (I_CLK),
    .i_srst     (I_SRST),
    .i_tick_pin (I_WDT_TICK_CLK),
    .o_tick     (tick)
  );

  // Bus handshake: one wait cycle for every access, more for a restart read.
  wire        req       = I_AVS_READ | I_AVS_WRITE;
  wire        rd_clear  = I_AVS_READ & (I_AVS_ADDRESS == wwdt_pkg::IDX_CLEAR);
  wire [1:0]  need      = rd_clear ? wwdt_pkg::SYNC_RD_CYC : wwdt_pkg::BUS_CYC;
  wire        waiting   = req & (bus_cnt != need);
  wire        wr_done   = I_AVS_WRITE & ~waiting & I_AVS_BYTEENABLE[0];
  wire [7:0]  wd        = I_AVS_WRITEDATA[7:0];
  wire        wr_ctrl   = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_CTRL);
  wire        wr_cfg    = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_CONFIG);
  wire        wr_ewc    = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_EARLY_WARN_CONTROL);
  wire        wr_ienclr = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_IRQ_ENABLE_CLEAR_REG);
  wire        wr_ienset = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_IRQ_ENABLE_SET_REG);
  wire        wr_flag   = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_IRQ_FLAG_REG);
  wire        wr_clear  = wr_done & (I_AVS_ADDRESS == wwdt_pkg::IDX_CLEAR);

  // Software view of running decides enable protection.
  wire        running_sw = ctrl_enable | lock;
  wire        start_wr   = wd[wwdt_pkg::CTRL_ENABLE] & ~ctrl_enable;
  wire        prot_ok    = ~running_sw | (start_wr & ~lock);
  wire        next_enable = lock ? ctrl_enable : wd[wwdt_pkg::CTRL_ENABLE];
  wire        next_wen    = (prot_ok | lock) ? wd[wwdt_pkg::CTRL_WEN] : ctrl_wen;
  wire        next_lock   = lock | (prot_ok & wd[wwdt_pkg::CTRL_LOCK]);

  // Tick-domain view: the counter follows only synchronised control values.
  wire        running    = en_eff | lock_eff;
  wire        active     = running & ~I_DBG_HALT & ~I_BACKUP_MODE;
  wire [16:0] closed     = wen_eff ? period_cycles(win_code) : 17'h00000;
  wire [16:0] total      = closed + period_cycles(per_code);
  wire [16:0] ew_point   = wen_eff ? closed : period_cycles(ew_code);
  wire [16:0] next_cnt   = cnt + 17'h00001;
  wire        step       = tick & active;
  wire        timeout    = step & (next_cnt == total);
  wire        ew_hit     = step & (next_cnt == ew_point) & ~timeout;
  wire        in_closed  = wen_eff & (cnt < closed);
  wire        key_ok     = (wd == wwdt_pkg::CLEAR_KEY);
  wire        bad_clear  = wr_clear & running & (~key_ok | in_closed);
  wire        good_clear = wr_clear & running & key_ok & ~in_closed;

  wire [31:0] rd_mux =
    (I_AVS_ADDRESS == wwdt_pkg::IDX_CTRL)     ? {24'h000000, lock, 4'h0, ctrl_wen, ctrl_enable, 1'b0} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_CONFIG)   ? {24'h000000, win_code, per_code} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_EARLY_WARN_CONTROL)   ? {28'h0000000, ew_code} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_IRQ_ENABLE_CLEAR_REG) ? {31'h00000000, irq_en} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_IRQ_ENABLE_SET_REG) ? {31'h00000000, irq_en} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_IRQ_FLAG_REG)  ? {31'h00000000, irq_flag} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_SYNCBUSY) ? {28'h0000000, sync_busy, 1'b0} :
    (I_AVS_ADDRESS == wwdt_pkg::IDX_CLEAR)    ? {24'h000000, clear_val} :
    32'h00000000;

  assign O_AVS_WAITREQUEST = waiting;
  assign O_IRQ             = irq_flag & irq_en;
  assign O_WAKE            = irq_flag;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      bus_cnt        <= 2'h0;
      O_AVS_READDATA <= 32'h00000000;
    end else begin
      bus_cnt        <= waiting ? bus_cnt + 2'h1 : 2'h0;
      O_AVS_READDATA <= I_AVS_READ ? rd_mux : 32'h00000000;
    end
  end

  // Power-on values are taken on the first edge after reset release.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      por_load    <= 1'b1;
      ctrl_enable <= 1'b0;
      ctrl_wen    <= 1'b0;
      lock        <= 1'b0;
      win_code    <= 4'h0;
      per_code    <= 4'h0;
      ew_code     <= 4'h0;
    end else if (por_load) begin
      por_load    <= 1'b0;
      ctrl_enable <= I_NVM_ENABLE;
      ctrl_wen    <= I_NVM_WEN;
      lock        <= I_NVM_LOCK;
      win_code    <= I_NVM_WINDOW;
      per_code    <= I_NVM_PER;
      ew_code     <= I_NVM_EWOFF;
    end else begin
      if (wr_ctrl) begin
        ctrl_enable <= next_enable;
        ctrl_wen    <= next_wen;
        lock        <= next_lock;
      end
      if (wr_cfg & ~running_sw) begin
        win_code <= wd[7:4];
        per_code <= wd[3:0];
      end
      if (wr_ewc & ~running_sw) begin
        ew_code <= wd[3:0];
      end
    end
  end

  // Control bits reach the counter only on a tick; busy shows the pending crossing.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      en_eff    <= 1'b0;
      wen_eff   <= 1'b0;
      lock_eff  <= 1'b0;
      sync_busy <= 3'h0;
    end else if (por_load) begin
      en_eff   <= I_NVM_ENABLE;
      wen_eff  <= I_NVM_WEN;
      lock_eff <= I_NVM_LOCK;
    end else begin
      if (tick) begin
        en_eff    <= ctrl_enable;
        wen_eff   <= ctrl_wen;
        lock_eff  <= lock;
        sync_busy <= 3'h0;
      end
      if (wr_ctrl) begin
        sync_busy <= 3'h7;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cnt         <= 17'h00000;
      O_SYS_RESET <= 1'b0;
      clear_val   <= 8'h00;
    end else begin
      O_SYS_RESET <= timeout | bad_clear;
      if (wr_clear) begin
        clear_val <= wd;
      end
      if (~running | good_clear | timeout | bad_clear) begin
        cnt <= 17'h00000;
      end else if (step) begin
        cnt <= next_cnt;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      irq_en   <= 1'b0;
      irq_flag <= 1'b0;
    end else begin
      if (wr_ienset & wd[wwdt_pkg::EW_BIT]) begin
        irq_en <= 1'b1;
      end else if (wr_ienclr & wd[wwdt_pkg::EW_BIT]) begin
        irq_en <= 1'b0;
      end
      // A new warning in the clearing cycle wins over the clear.
      if (ew_hit) begin
        irq_flag <= 1'b1;
      end else if (wr_flag & wd[wwdt_pkg::EW_BIT]) begin
        irq_flag <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST | por_load);

  sequence key_write_s;
    wr_clear & running & key_ok;
  endsequence
  sequence closed_phase_s;
    in_closed;
  endsequence

  bad_key_a: assert property (wr_clear & running & ~key_ok |=> O_SYS_RESET)
    else $error("non-key restart did not reset");
  good_key_a: assert property (key_write_s ##0 !closed_phase_s |=> cnt == 17'h00000 && !O_SYS_RESET)
    else $error("key restart did not clear counter");
  closed_clear_a: assert property (key_write_s ##0 closed_phase_s |=> O_SYS_RESET)
    else $error("restart in closed window did not reset");
  timeout_reset_a: assert property (step & (next_cnt == total) |=> O_SYS_RESET ##1 !O_SYS_RESET)
    else $error("timeout did not give one reset pulse");
  protect_cfg_a: assert property (wr_cfg & running_sw |=> $stable(per_code) && $stable(win_code))
    else $error("protected config changed while running");
  stop_refuse_a: assert property (wr_ctrl & lock |=> ctrl_enable == $past(ctrl_enable) && lock)
    else $error("locked watchdog stopped");
  stopped_cnt_a: assert property (!running |=> cnt == 17'h00000)
    else $error("counter moved while stopped");
  ew_flag_a: assert property (ew_hit |=> irq_flag ##0 (O_IRQ == irq_en))
    else $error("early warning did not set flag");
  flag_clear_a: assert property (wr_flag & wd[0] & !ew_hit |=> !irq_flag && !O_IRQ)
    else $error("flag not cleared by write of one");
  clear_read_a: assert property (rd_clear & bus_cnt == 2'h0 |-> O_AVS_WAITREQUEST[*3] ##1 !O_AVS_WAITREQUEST)
    else $error("restart read not stalled three cycles");
  sync_hold_a: assert property (wr_ctrl |=> sync_busy[1] && en_eff == $past(en_eff))
    else $error("control write bypassed synchronisation");
  halt_cnt_a: assert property (I_DBG_HALT & running & !good_clear & !bad_clear |=> $stable(cnt))
    else $error("counter moved during debug halt");

  // Interrupt enable follows the set and clear registers.
  ien_set_a: assert property (wr_ienset & wd[0] |=> irq_en)
    else $error("enable set write ignored");
  ien_clear_a: assert property (wr_ienclr & wd[0] |=> !irq_en)
    else $error("enable clear write ignored");

  // The lock only ever goes from zero to one until power-on reset.
  lock_hold_a: assert property (lock |=> lock)
    else $error("persistent lock dropped");
  ew_protect_a: assert property (wr_ewc & running_sw |=> $stable(ew_code))
    else $error("warning delay changed while running");

  // Protected control bits ride along with any write while stopped; once locked, window select rides along with every write.
  start_window_a: assert property (wr_ctrl & ~running_sw & wd[1] & wd[2] |=> ctrl_wen)
    else $error("window bit lost in starting write");
  stop_window_a: assert property (wr_ctrl & ctrl_enable & ~lock & ~wd[1] & wd[2] & ~ctrl_wen |=> !ctrl_wen)
    else $error("window bit taken in stopping write");
  start_run_a: assert property (wr_ctrl & ~lock & wd[1] |=> ctrl_enable)
    else $error("enable write did not start");
  stop_run_a: assert property (wr_ctrl & ~lock & ~wd[1] |=> !ctrl_enable)
    else $error("disable write did not stop");

  // Backup mode freezes the counter like a debug halt.
  backup_cnt_a: assert property (I_BACKUP_MODE & running & !good_clear & !bad_clear |=> $stable(cnt))
    else $error("counter moved in backup mode");
  quiet_reset_a: assert property (!timeout & !bad_clear |=> !O_SYS_RESET)
    else $error("system reset without cause");
  idle_clear_a: assert property (wr_clear & !running |=> !O_SYS_RESET)
    else $error("restart while stopped reset the system");
  sync_done_a: assert property (tick & !wr_ctrl |=> sync_busy == 3'h0)
    else $error("busy stayed after tick");

  // Each enabled tick without a timeout or restart advances the counter by exactly one.
  count_step_a: assert property (step & !good_clear & !bad_clear & !timeout |=> cnt == $past(cnt) + 17'h00001)
    else $error("counter did not advance on tick");
  ew_normal_a: assert property (step & !wen_eff & (next_cnt == period_cycles(ew_code)) & !timeout |=> irq_flag)
    else $error("normal early warning missed");
endmodule

// ### verilog/wwdt_pkg.sv
// Package of register map, field positions and timing constants for the windowed watchdog.
//
// Contract
// - Report stopped when run-enable is zero, else normal or window, optional early warning.
// - Ignore protected setting writes while the watchdog runs.
// - Take protected control bits with a run-enable-1 write, never with run-enable-0; any write takes them while stopped, and window select while locked.
// - Load run, lock, window select and periods from nonvolatile values after power-on.
// - Writing 1 to run-enable starts, writing 0 stops the watchdog.
// - Refuse to stop while the persistent-run lock is set.
// - Normal mode resets the system when the period ends without a restart.
// - Key 0xA5 written to restart clears the counter and starts a fresh period.
// - Any other restart value resets the system at once.
// - Twelve timeout periods are selectable, about 8 ms to 16 s.
// - Early warning disabled by default; set register enables, clear register disables.
// - Normal mode raises early warning at the programmed delay.
// - Window mode resets on restart in the closed window, accepts it when open.
// - Closed period from window field, open from timeout field; total is their sum.
// - Window mode raises early warning when the open window begins.
// - Early warning sets its flag and acts as a wake-up source.
// - Interrupt asserts while flag and enable are set until either is removed.
// - All interrupt requests are ORed onto one request line.
// - Keep counting in sleep modes with the tick clock, except backup mode.
// - Run-enable, window select and lock writes cross into the tick domain first.
// - Restart register reads are synchronized before data returns.
// - The set lock keeps the watchdog running; only power-on reset clears it.
// - The counter runs from a separate slow tick clock of about 1 kHz.
// - Period codes 0x0 to 0xB give 8 times two to the code cycles.
// - Counting halts while the processor is halted in debug.
package wwdt_pkg;
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_CONFIG   = 4'h1;
  localparam logic [3:0] IDX_EARLY_WARN_CONTROL   = 4'h2;
  localparam logic [3:0] IDX_IRQ_ENABLE_CLEAR_REG = 4'h4;
  localparam logic [3:0] IDX_IRQ_ENABLE_SET_REG = 4'h5;
  localparam logic [3:0] IDX_IRQ_FLAG_REG  = 4'h6;
  localparam logic [3:0] IDX_SYNCBUSY = 4'h8;
  localparam logic [3:0] IDX_CLEAR    = 4'hC;
  localparam int         CTRL_ENABLE  = 1;
  localparam int         CTRL_WEN     = 2;
  localparam int         CTRL_LOCK    = 7;
  localparam int         SB_ENABLE    = 1;
  localparam int         SB_WEN       = 2;
  localparam int         SB_LOCK      = 3;
  localparam int         EW_BIT       = 0;
  localparam logic [7:0] CLEAR_KEY    = 8'hA5;
  localparam logic [3:0] CODE_MAX     = 4'hB;
  localparam logic [16:0] PERIOD_BASE = 17'h00008;
  localparam logic [16:0] PERIOD_TOP  = 17'h04000;
  localparam logic [1:0] SYNC_RD_CYC  = 2'h3;
  localparam logic [1:0] BUS_CYC      = 2'h1;
endpackage

// ### verilog/wwdt_tick_sync.sv
// Tick clock pin synchroniser producing a one-cycle enable on each rising edge.
`timescale 1ns/1ps
module wwdt_tick_sync (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_tick_pin,
  output logic      o_tick
);
  logic s1;
  logic s2;
  logic s3;
  logic lvl;
  wire  agree = (s2 == s3);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      lvl <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      s1 <= i_tick_pin;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        lvl <= s3;
      end
      // A change counts only once the second and third stages agree.
      o_tick <= agree & s3 & ~lvl;
    end
  end
endmodule

// ### test/wwdt_core_tb_top.sv
// Self-checking testbench for the windowed watchdog top.
`timescale 1ns/1ps
module wwdt_core_tb_top;
  logic        I_CLK = 1'b0, I_SRST = 1'b1, I_WDT_TICK_CLK = 1'b0, I_DBG_HALT = 1'b0, I_BACKUP_MODE = 1'b0;
  logic        I_NVM_ENABLE = 1'b0, I_NVM_LOCK = 1'b0, I_NVM_WEN = 1'b0;
  logic [3:0]  I_NVM_WINDOW = 4'h1, I_NVM_PER = 4'h0, I_NVM_EWOFF = 4'h1;
  logic [3:0]  I_AVS_ADDRESS = 4'h0, I_AVS_BYTEENABLE = 4'hF;
  logic        I_AVS_READ = 1'b0, I_AVS_WRITE = 1'b0;
  logic [31:0] I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA, q;
  logic        O_AVS_WAITREQUEST, O_IRQ, O_WAKE, O_SYS_RESET;
  int          err_count = 0, total_checks = 0, rst_seen = 0, last_wait = 0;

  wwdt_core i_wwdt_core (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_WDT_TICK_CLK(I_WDT_TICK_CLK),
    .I_DBG_HALT(I_DBG_HALT), .I_BACKUP_MODE(I_BACKUP_MODE), .I_NVM_ENABLE(I_NVM_ENABLE),
    .I_NVM_LOCK(I_NVM_LOCK), .I_NVM_WEN(I_NVM_WEN), .I_NVM_WINDOW(I_NVM_WINDOW), .I_NVM_PER(I_NVM_PER),
    .I_NVM_EWOFF(I_NVM_EWOFF), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_IRQ(O_IRQ),
    .O_WAKE(O_WAKE), .O_SYS_RESET(O_SYS_RESET));

  initial begin
    forever #12.5 I_CLK = ~I_CLK;
  end

  always @(posedge I_CLK) begin
    if (O_SYS_RESET === 1'b1) rst_seen <= rst_seen + 1;
  end

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request stands until the rising edge at which waitrequest is sampled low; read data is taken there.
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= {24'h0, d};
    I_AVS_WRITE <= wr;
    I_AVS_READ <= !wr;
    last_wait = 0;
    do begin
      @(posedge I_CLK);
      last_wait++;
    end while (O_AVS_WAITREQUEST !== 1'b0 && last_wait < 20);
    q = O_AVS_READDATA;
    I_AVS_WRITE <= 1'b0;
    I_AVS_READ <= 1'b0;
    if (last_wait >= 20) begin
      chk("waitrequest", 32'h0, 32'h1);
      close_out();
    end
    @(posedge I_CLK);
  endtask

  task tick(input int n);
    repeat (n) begin
      I_WDT_TICK_CLK <= 1'b1;
      repeat (4) @(posedge I_CLK);
      I_WDT_TICK_CLK <= 1'b0;
      repeat (4) @(posedge I_CLK);
    end
  endtask

  task sync_wait;
    int n;
    n = 0;
    bus(1'b0, wwdt_pkg::IDX_SYNCBUSY, 8'h00);
    while (q !== 32'h0 && n < 4) begin
      tick(1);
      bus(1'b0, wwdt_pkg::IDX_SYNCBUSY, 8'h00);
      n++;
    end
    chk("syncbusy", 32'h0, q);
  endtask

  // The start edge may or may not count, so the pulse is allowed in the last two ticks of the period.
  task expect_reset(input int p);
    rst_seen = 0;
    tick(p - 2);
    chk("early reset", 32'h0, rst_seen);
    tick(2);
    chk("timeout reset", 32'h1, rst_seen);
  endtask

  task s_por;
    bus(1'b0, wwdt_pkg::IDX_CTRL, 8'h00);
    chk("ctrl por", 32'h0, q);
    bus(1'b0, wwdt_pkg::IDX_CONFIG, 8'h00);
    chk("config por", 32'h10, q);
    bus(1'b0, wwdt_pkg::IDX_EARLY_WARN_CONTROL, 8'h00);
    chk("early_warn_control por", 32'h01, q);
    bus(1'b0, wwdt_pkg::IDX_IRQ_ENABLE_SET_REG, 8'h00);
    chk("irq enable por", 32'h0, q);
    bus(1'b0, 4'h3, 8'h00);
    chk("unmapped", 32'h0, q);
  endtask

  task s_normal;
    bus(1'b1, wwdt_pkg::IDX_CONFIG, 8'h00);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h02);
    bus(1'b0, wwdt_pkg::IDX_SYNCBUSY, 8'h00);
    chk("syncbusy enable", 32'h1, {31'h0, q[wwdt_pkg::SB_ENABLE]});
    sync_wait();
    expect_reset(8);
    tick(5);
    bus(1'b1, wwdt_pkg::IDX_CLEAR, 8'hA5);
    bus(1'b0, wwdt_pkg::IDX_CLEAR, 8'h00);
    chk("clear read", 32'hA5, q);
    chk("clear read stall", 32'h4, last_wait);
    expect_reset(8);
    bus(1'b1, wwdt_pkg::IDX_CONFIG, 8'h33);
    bus(1'b0, wwdt_pkg::IDX_CONFIG, 8'h00);
    chk("config protected", 32'h0, q);
    rst_seen = 0;
    bus(1'b1, wwdt_pkg::IDX_CLEAR, 8'h3C);
    repeat (3) @(posedge I_CLK);
    chk("bad key reset", 32'h1, rst_seen);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h04);
    bus(1'b0, wwdt_pkg::IDX_CTRL, 8'h00);
    chk("ctrl stop", 32'h0, q);
    sync_wait();
    rst_seen = 0;
    tick(20);
    chk("stopped reset", 32'h0, rst_seen);
  endtask

  task s_ew;
    bus(1'b1, wwdt_pkg::IDX_CONFIG, 8'h01);
    bus(1'b1, wwdt_pkg::IDX_EARLY_WARN_CONTROL, 8'h00);
    bus(1'b1, wwdt_pkg::IDX_IRQ_FLAG_REG, 8'h01);
    bus(1'b1, wwdt_pkg::IDX_IRQ_ENABLE_SET_REG, 8'h01);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h02);
    sync_wait();
    rst_seen = 0;
    tick(6);
    chk("wake early", 32'h0, O_WAKE);
    tick(2);
    chk("wake", 32'h1, O_WAKE);
    chk("irq", 32'h1, O_IRQ);
    bus(1'b0, wwdt_pkg::IDX_IRQ_FLAG_REG, 8'h00);
    chk("flag", 32'h1, q);
    bus(1'b1, wwdt_pkg::IDX_IRQ_ENABLE_CLEAR_REG, 8'h01);
    chk("irq disabled", 32'h0, O_IRQ);
    bus(1'b1, wwdt_pkg::IDX_IRQ_FLAG_REG, 8'h00);
    chk("flag kept", 32'h1, O_WAKE);
    bus(1'b1, wwdt_pkg::IDX_IRQ_FLAG_REG, 8'h01);
    chk("flag cleared", 32'h0, O_WAKE);
    chk("no reset", 32'h0, rst_seen);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h00);
    sync_wait();
  endtask

  task s_win;
    bus(1'b1, wwdt_pkg::IDX_CONFIG, 8'h00);
    bus(1'b1, wwdt_pkg::IDX_IRQ_ENABLE_SET_REG, 8'h01);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h06);
    bus(1'b0, wwdt_pkg::IDX_CTRL, 8'h00);
    chk("ctrl window", 32'h06, q);
    sync_wait();
    rst_seen = 0;
    tick(3);
    bus(1'b1, wwdt_pkg::IDX_CLEAR, 8'hA5);
    repeat (3) @(posedge I_CLK);
    chk("closed clear", 32'h1, rst_seen);
    rst_seen = 0;
    tick(6);
    chk("wake closed", 32'h0, O_WAKE);
    tick(2);
    chk("wake open", 32'h1, O_WAKE);
    chk("irq open", 32'h1, O_IRQ);
    bus(1'b1, wwdt_pkg::IDX_CLEAR, 8'hA5);
    repeat (3) @(posedge I_CLK);
    chk("open clear", 32'h0, rst_seen);
    expect_reset(16);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h00);
    sync_wait();
  endtask

  task s_lock;
    I_NVM_ENABLE <= 1'b1;
    I_NVM_LOCK <= 1'b1;
    I_SRST <= 1'b1;
    repeat (2) @(posedge I_CLK);
    I_SRST <= 1'b0;
    repeat (2) @(posedge I_CLK);
    bus(1'b0, wwdt_pkg::IDX_CTRL, 8'h00);
    chk("ctrl lock por", 32'h82, q);
    bus(1'b1, wwdt_pkg::IDX_CTRL, 8'h00);
    bus(1'b0, wwdt_pkg::IDX_CTRL, 8'h00);
    chk("ctrl locked", 32'h82, q);
    sync_wait();
    rst_seen = 0;
    I_DBG_HALT <= 1'b1;
    tick(12);
    chk("halt reset", 32'h0, rst_seen);
    I_DBG_HALT <= 1'b0;
    I_BACKUP_MODE <= 1'b1;
    tick(12);
    chk("backup reset", 32'h0, rst_seen);
    I_BACKUP_MODE <= 1'b0;
    expect_reset(8);
  endtask

  initial begin
    repeat (4) @(posedge I_CLK);
    I_SRST <= 1'b0;
    repeat (2) @(posedge I_CLK);
    s_por();
    s_normal();
    s_ew();
    s_win();
    s_lock();
    close_out();
  end
endmodule
